// file: hw/spcs_defs.svh
// Register map, field positions, reset values and timing counts of the SPI control block
`ifndef SPCS_DEFS_SVH
`define SPCS_DEFS_SVH

// ****************************************
// Register addresses
// ****************************************
`define SPCS_ADDR_CTRL      8'hf8
`define SPCS_ADDR_CFG       8'ha1
`define SPCS_ADDR_DATA      8'ha3

// ****************************************
// Control/status and config fields
// ****************************************
`define SPCS_CTRL_WRITE_COLLISION_FLAG      6
`define SPCS_CTRL_MODE_FAULT_FLAG      5
`define SPCS_CTRL_OVRN      4
`define SPCS_CTRL_SSMD_HI   3
`define SPCS_CTRL_SSMD_LO   2
`define SPCS_CTRL_TRANSMIT_BUFFER_EMPTY_FLAG     1
`define SPCS_CTRL_EN        0
`define SPCS_CFG_MASTER_MODE_ENABLE      6

// ****************************************
// Reset and idle values
// ****************************************
`define SPCS_SSMD_RESET     2'h0
`define SPCS_IDLE_WORD      8'hff

// ****************************************
// Timing
// ****************************************
`define SPCS_SCK_HALF_NS    16
`define SPCS_CLK_NS         4
`define SPCS_SCK_HALF_CYC   ((`SPCS_SCK_HALF_NS + `SPCS_CLK_NS - 1) / `SPCS_CLK_NS)

`endif

// file: hw/spcs_pkg.sv
// Types shared by the SPI control block
package spcs_pkg;

    typedef enum logic [1:0] {
        SPCS_SSMD_3WIRE  = 2'b00,
        SPCS_SSMD_4SLAVE = 2'b01,
        SPCS_SSMD_4MST0  = 2'b10,
        SPCS_SSMD_4MST1  = 2'b11
    } spcs_ssmd_t;

    typedef enum logic [0:0] {
        SPCS_M_IDLE  = 1'b0,
        SPCS_M_SHIFT = 1'b1
    } spcs_mstate_t;

endpackage

// file: hw/spcs_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module spcs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wptr_r;
    logic [AW:0]      wptr_nxt;
    logic [AW:0]      rptr_r;
    logic [AW:0]      rptr_nxt;
    logic             push;
    logic             pop;

    // ****************************************
    // Pointers
    // ****************************************
    always_comb begin
        in_ready  = (wptr_r[AW-1:0] != rptr_r[AW-1:0]) || (wptr_r[AW] == rptr_r[AW]);
        out_valid = (wptr_r != rptr_r);
        out_data  = mem_r[rptr_r[AW-1:0]];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wptr_nxt  = push ? wptr_r + 1'b1 : wptr_r;
        rptr_nxt  = pop ? rptr_r + 1'b1 : rptr_r;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wptr_r <= '0;
            rptr_r <= '0;
        end else begin
            wptr_r <= wptr_nxt;
            rptr_r <= rptr_nxt;
        end
    end

    // ****************************************
    // Storage
    // ****************************************
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wptr_r[AW-1:0]] <= in_data;
        end
    end

endmodule

// file: hw/spcs_top.sv
// SPI port control/status register, flags and shift engines
`include "spcs_defs.svh"
`timescale 1ns/100ps
module spcs_top #(
    parameter int SCK_HALF = `SPCS_SCK_HALF_CYC,
    parameter int RX_DEPTH = 4
) (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr_en,
    input  wire logic       sfr_rd_en,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata_r,
    output logic            spi_irq_r,
    input  wire logic       sck_in,
    output logic            sck_out_r,
    output logic            sck_oe_r,
    input  wire logic       mosi_in,
    output logic            mosi_out_r,
    output logic            mosi_oe_r,
    input  wire logic       miso_in,
    output logic            miso_out_r,
    output logic            miso_oe_r,
    input  wire logic       slave_select_pin_in,
    output logic            slave_select_pin_out_r,
    output logic            slave_select_pin_oe_r
);
    // ****************************************
    // Declarations
    // ****************************************
    logic                 port_enable_bit_r, port_enable_bit_nxt;
    logic                 master_mode_enable_r, master_mode_enable_nxt;
    spcs_pkg::spcs_ssmd_t slave_select_mode_field_r, slave_select_mode_field_nxt;
    logic                 mode_fault_flag_r, mode_fault_flag_nxt;
    logic                 receive_overrun_flag_r, receive_overrun_flag_nxt;
    logic                 write_collision_flag_r, write_collision_flag_nxt;
    logic [7:0]           tx_buf_r, tx_buf_nxt;
    logic                 tx_full_r, tx_full_nxt;
    logic [7:0]           rdata_nxt;
    logic                 irq_nxt;
    logic                 sel_s1_r, sel_s2_r, miso_s1_r, miso_s2_r;
    logic                 rxt_s1_r, rxt_s2_r, rxt_s3_r;
    logic                 ack_s1_r, ack_s2_r, ack_s3_r;
    logic                 slave_on_r, slave_on_nxt;
    logic                 wr_ctrl, wr_cfg, wr_data, rd_data;
    logic                 collision, slave_byte, slave_ack;
    logic                 push_valid, push_ready;
    logic [7:0]           push_data;
    logic                 fifo_valid;
    logic [7:0]           fifo_data;
    logic                 oe_nxt, miso_oe_nxt;
    // Master engine
    spcs_pkg::spcs_mstate_t mst_r, mst_nxt;
    logic [15:0]          div_r, div_nxt;
    logic [3:0]           phase_r, phase_nxt;
    logic [7:0]           msh_r, msh_nxt;
    logic                 sck_nxt, mosi_nxt, mst_done;
    // Link domain
    logic                 link_clear;
    logic                 lfull_s1_r, lfull_s2_r;
    logic [7:0]           ltx_sh_r, ltx_sh_nxt;
    logic [2:0]           ltx_cnt_r;
    logic                 ltx_ack_r, ltx_ack_nxt, miso_nxt;
    logic [7:0]           lrx_sh_r, lrx_word_r;
    logic [2:0]           lrx_cnt_r;
    logic                 lrx_tg_r;

    // ****************************************
    // Register access decode
    // ****************************************
    always_comb begin
        wr_ctrl = sfr_wr_en && (sfr_addr == `SPCS_ADDR_CTRL);
        wr_cfg  = sfr_wr_en && (sfr_addr == `SPCS_ADDR_CFG);
        wr_data = sfr_wr_en && (sfr_addr == `SPCS_ADDR_DATA);
        rd_data = sfr_rd_en && (sfr_addr == `SPCS_ADDR_DATA);
    end

    // ****************************************
    // Pin synchronisers and crossing edges
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sel_s1_r  <= 1'b1;
            sel_s2_r  <= 1'b1;
            miso_s1_r <= 1'b0;
            miso_s2_r <= 1'b0;
            rxt_s1_r  <= 1'b0;
            rxt_s2_r  <= 1'b0;
            rxt_s3_r  <= 1'b0;
            ack_s1_r  <= 1'b0;
            ack_s2_r  <= 1'b0;
            ack_s3_r  <= 1'b0;
        end else begin
            sel_s1_r  <= slave_select_pin_in;
            sel_s2_r  <= sel_s1_r;
            miso_s1_r <= miso_in;
            miso_s2_r <= miso_s1_r;
            rxt_s1_r  <= lrx_tg_r;
            rxt_s2_r  <= rxt_s1_r;
            rxt_s3_r  <= rxt_s2_r;
            ack_s1_r  <= ltx_ack_r;
            ack_s2_r  <= ack_s1_r;
            ack_s3_r  <= ack_s2_r;
        end
    end

    // ****************************************
    // Control, flags and transmit buffer
    // ****************************************
    always_comb begin
        collision  = port_enable_bit_r && master_mode_enable_r && !sel_s2_r
                     && (slave_select_mode_field_r == spcs_pkg::SPCS_SSMD_4SLAVE);
        slave_byte = (rxt_s2_r != rxt_s3_r);
        slave_ack  = (ack_s2_r != ack_s3_r);
        push_valid = mst_done || slave_byte;
        push_data  = mst_done ? msh_nxt : lrx_word_r;

        port_enable_bit_nxt         = port_enable_bit_r;
        slave_select_mode_field_nxt = slave_select_mode_field_r;
        master_mode_enable_nxt      = master_mode_enable_r;
        mode_fault_flag_nxt         = mode_fault_flag_r;
        receive_overrun_flag_nxt    = receive_overrun_flag_r;
        write_collision_flag_nxt    = write_collision_flag_r;
        if (wr_ctrl) begin
            port_enable_bit_nxt         = sfr_wdata[`SPCS_CTRL_EN];
            slave_select_mode_field_nxt =
                spcs_pkg::spcs_ssmd_t'(sfr_wdata[`SPCS_CTRL_SSMD_HI:`SPCS_CTRL_SSMD_LO]);
            mode_fault_flag_nxt         = sfr_wdata[`SPCS_CTRL_MODE_FAULT_FLAG];
            receive_overrun_flag_nxt    = sfr_wdata[`SPCS_CTRL_OVRN];
            write_collision_flag_nxt    = sfr_wdata[`SPCS_CTRL_WRITE_COLLISION_FLAG];
        end
        if (wr_cfg) begin
            master_mode_enable_nxt = sfr_wdata[`SPCS_CFG_MASTER_MODE_ENABLE];
        end
        // Hardware sets win over a software clear in the same cycle
        if (collision) begin
            mode_fault_flag_nxt = 1'b1;
        end
        if (push_valid && !push_ready) begin
            receive_overrun_flag_nxt = 1'b1;
        end

        tx_buf_nxt  = tx_buf_r;
        tx_full_nxt = tx_full_r;
        if ((mst_r == spcs_pkg::SPCS_M_IDLE && mst_nxt == spcs_pkg::SPCS_M_SHIFT) || slave_ack) begin
            tx_full_nxt = 1'b0;
        end
        if (wr_data) begin
            if (tx_full_r) begin
                write_collision_flag_nxt = 1'b1;
            end else begin
                tx_buf_nxt  = sfr_wdata;
                tx_full_nxt = 1'b1;
            end
        end

        irq_nxt = mode_fault_flag_nxt || receive_overrun_flag_nxt;
        slave_on_nxt = port_enable_bit_r && !master_mode_enable_r;
        oe_nxt       = port_enable_bit_r && master_mode_enable_r;
        miso_oe_nxt  = slave_on_r && (!sel_s2_r
                       || slave_select_mode_field_r == spcs_pkg::SPCS_SSMD_3WIRE);

        unique case (sfr_addr)
            `SPCS_ADDR_CTRL: rdata_nxt = {1'b0, write_collision_flag_r, mode_fault_flag_r,
                                          receive_overrun_flag_r, slave_select_mode_field_r,
                                          !tx_full_r, port_enable_bit_r};
            `SPCS_ADDR_CFG:  rdata_nxt = {1'b0, master_mode_enable_r, 6'h00};
            `SPCS_ADDR_DATA: rdata_nxt = fifo_valid ? fifo_data : 8'h00;
            default:         rdata_nxt = 8'h00;
        endcase
        if (!sfr_rd_en) begin
            rdata_nxt = sfr_rdata_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            port_enable_bit_r         <= 1'b0;
            master_mode_enable_r      <= 1'b0;
            slave_select_mode_field_r <= spcs_pkg::spcs_ssmd_t'(`SPCS_SSMD_RESET);
            mode_fault_flag_r         <= 1'b0;
            receive_overrun_flag_r    <= 1'b0;
            write_collision_flag_r    <= 1'b0;
            tx_buf_r                  <= 8'h00;
            tx_full_r                 <= 1'b0;
            sfr_rdata_r               <= 8'h00;
            spi_irq_r                 <= 1'b0;
            slave_on_r                <= 1'b0;
            sck_oe_r                  <= 1'b0;
            mosi_oe_r                 <= 1'b0;
            miso_oe_r                 <= 1'b0;
            slave_select_pin_out_r    <= 1'b1;
            slave_select_pin_oe_r     <= 1'b0;
        end else begin
            port_enable_bit_r         <= port_enable_bit_nxt;
            master_mode_enable_r      <= master_mode_enable_nxt;
            slave_select_mode_field_r <= slave_select_mode_field_nxt;
            mode_fault_flag_r         <= mode_fault_flag_nxt;
            receive_overrun_flag_r    <= receive_overrun_flag_nxt;
            write_collision_flag_r    <= write_collision_flag_nxt;
            tx_buf_r                  <= tx_buf_nxt;
            tx_full_r                 <= tx_full_nxt;
            sfr_rdata_r               <= rdata_nxt;
            spi_irq_r                 <= irq_nxt;
            slave_on_r                <= slave_on_nxt;
            sck_oe_r                  <= oe_nxt;
            mosi_oe_r                 <= oe_nxt;
            miso_oe_r                 <= miso_oe_nxt;
            slave_select_pin_out_r    <= slave_select_mode_field_r[0];
            slave_select_pin_oe_r     <= port_enable_bit_r
                                         && slave_select_mode_field_r[1];
        end
    end

    // ****************************************
    // Receive buffer
    // ****************************************
    spcs_fifo #(
        .WIDTH (8),
        .DEPTH (RX_DEPTH)
    ) u_rx_fifo (
        .clk       (ref_clk),
        .reset     (reset),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (fifo_valid),
        .out_ready (rd_data),
        .out_data  (fifo_data)
    );

    // ****************************************
    // Master engine: sck rises to drive, falls to sample
    // ****************************************
    always_comb begin
        mst_nxt   = mst_r;
        div_nxt   = div_r;
        phase_nxt = phase_r;
        msh_nxt   = msh_r;
        sck_nxt   = sck_out_r;
        mosi_nxt  = mosi_out_r;
        mst_done  = 1'b0;
        unique case (mst_r)
            spcs_pkg::SPCS_M_IDLE: begin
                sck_nxt = 1'b0;
                if (oe_nxt && tx_full_r && !collision) begin
                    mst_nxt   = spcs_pkg::SPCS_M_SHIFT;
                    msh_nxt   = tx_buf_r;
                    div_nxt   = 16'h0000;
                    phase_nxt = 4'h0;
                end
            end
            spcs_pkg::SPCS_M_SHIFT: begin
                if (!port_enable_bit_r) begin
                    mst_nxt = spcs_pkg::SPCS_M_IDLE;
                end else if (div_r == 16'(SCK_HALF - 1)) begin
                    div_nxt   = 16'h0000;
                    phase_nxt = phase_r + 4'h1;
                    if (!phase_r[0]) begin
                        sck_nxt  = 1'b1;
                        mosi_nxt = msh_r[7];
                    end else begin
                        sck_nxt = 1'b0;
                        msh_nxt = {msh_r[6:0], miso_s2_r};
                        if (phase_r == 4'hf) begin
                            mst_done = 1'b1;
                            mst_nxt  = spcs_pkg::SPCS_M_IDLE;
                        end
                    end
                end else begin
                    div_nxt = div_r + 16'h0001;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mst_r      <= spcs_pkg::SPCS_M_IDLE;
            div_r      <= 16'h0000;
            phase_r    <= 4'h0;
            msh_r      <= 8'h00;
            sck_out_r  <= 1'b0;
            mosi_out_r <= 1'b0;
        end else begin
            mst_r      <= mst_nxt;
            div_r      <= div_nxt;
            phase_r    <= phase_nxt;
            msh_r      <= msh_nxt;
            sck_out_r  <= sck_nxt;
            mosi_out_r <= mosi_nxt;
        end
    end

    // ****************************************
    // Slave link logic on the peer's sck
    // ****************************************
    // Frame boundary: deselect or disable clears the transmit counter without an sck edge, the receive counter on the next falling sck
    assign link_clear = !slave_on_r || (slave_select_pin_in
                        && slave_select_mode_field_r != spcs_pkg::SPCS_SSMD_3WIRE);

    always_comb begin
        if (ltx_cnt_r == 3'h0) begin
            miso_nxt    = lfull_s2_r ? tx_buf_r[7] : 1'b1;
            ltx_sh_nxt  = lfull_s2_r ? {tx_buf_r[6:0], 1'b0} : `SPCS_IDLE_WORD;
            ltx_ack_nxt = lfull_s2_r ? !ltx_ack_r : ltx_ack_r;
        end else begin
            miso_nxt    = ltx_sh_r[7];
            ltx_sh_nxt  = {ltx_sh_r[6:0], 1'b0};
            ltx_ack_nxt = ltx_ack_r;
        end
    end

    always_ff @(posedge sck_in or posedge link_clear) begin
        if (link_clear) begin
            lfull_s1_r <= 1'b0;
            lfull_s2_r <= 1'b0;
            ltx_sh_r   <= 8'h00;
            ltx_cnt_r  <= 3'h0;
            miso_out_r <= 1'b1;
        end else begin
            lfull_s1_r <= tx_full_r;
            lfull_s2_r <= lfull_s1_r;
            ltx_sh_r   <= ltx_sh_nxt;
            ltx_cnt_r  <= ltx_cnt_r + 3'h1;
            miso_out_r <= miso_nxt;
        end
    end

    // Toggles survive frame clears so no crossing event is lost
    always_ff @(posedge sck_in or posedge reset) begin
        if (reset) begin
            ltx_ack_r <= 1'b0;
        end else if (!link_clear) begin
            ltx_ack_r <= ltx_ack_nxt;
        end
    end

    always_ff @(negedge sck_in or posedge reset) begin
        if (reset) begin
            lrx_sh_r   <= 8'h00;
            lrx_cnt_r  <= 3'h0;
            lrx_word_r <= 8'h00;
            lrx_tg_r   <= 1'b0;
        end else if (link_clear) begin
            lrx_cnt_r <= 3'h0;
        end else begin
            lrx_sh_r  <= {lrx_sh_r[6:0], mosi_in};
            lrx_cnt_r <= lrx_cnt_r + 3'h1;
            if (lrx_cnt_r == 3'h7) begin
                lrx_word_r <= {lrx_sh_r[6:0], mosi_in};
                lrx_tg_r   <= !lrx_tg_r;
            end
        end
    end

endmodule

// file: tb/spcs_chk.sv
// Concurrent checks on the SPI control block ports
`include "spcs_defs.svh"
`timescale 1ns/100ps
module spcs_chk (
    input wire logic       ref_clk,
    input wire logic       reset,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr_en,
    input wire logic       sfr_rd_en,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata_r,
    input wire logic       spi_irq_r,
    input wire logic       sck_oe_r,
    input wire logic       mosi_oe_r,
    input wire logic       miso_oe_r,
    input wire logic       slave_select_pin_in,
    input wire logic       slave_select_pin_out_r,
    input wire logic       slave_select_pin_oe_r
);
    logic [7:0] ctl_r;
    logic [7:0] ctl_nxt;
    logic [7:0] cfg_r;
    logic [7:0] cfg_nxt;
    logic [1:0] ctl_age_r;
    logic [1:0] ctl_age_nxt;
    logic [1:0] cfg_age_r;
    logic [1:0] cfg_age_nxt;
    logic       wr_ctl;
    logic       wr_cfg;
    logic       mf_cond;

    assign wr_ctl = sfr_wr_en && sfr_addr == `SPCS_ADDR_CTRL;
    assign wr_cfg = sfr_wr_en && sfr_addr == `SPCS_ADDR_CFG;
    assign mf_cond = ctl_age_r == 2'h3 && cfg_age_r == 2'h3 && ctl_r[0]
        && ctl_r[3:2] == 2'h1 && cfg_r[`SPCS_CFG_MASTER_MODE_ENABLE] && !slave_select_pin_in;

    // ****
    // Shadow of software bits and cycles since their last write
    // ****
    always_comb begin
        ctl_nxt = wr_ctl ? sfr_wdata : ctl_r;
        cfg_nxt = wr_cfg ? sfr_wdata : cfg_r;
        ctl_age_nxt = wr_ctl ? 2'h0 : ctl_age_r + {1'b0, ctl_age_r != 2'h3};
        cfg_age_nxt = wr_cfg ? 2'h0 : cfg_age_r + {1'b0, cfg_age_r != 2'h3};
        if (reset) begin
            ctl_nxt = 8'h00;
            cfg_nxt = 8'h00;
            ctl_age_nxt = 2'h3;
            cfg_age_nxt = 2'h3;
        end
    end

    always_ff @(posedge ref_clk) begin
        ctl_r <= ctl_nxt;
        cfg_r <= cfg_nxt;
        ctl_age_r <= ctl_age_nxt;
        cfg_age_r <= cfg_age_nxt;
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    mf_sets_irq_a : assert property (mf_cond [*6] |-> spi_irq_r)
        else $error("mode collision did not raise the interrupt");
    irq_sw_clear_a : assert property ($fell(spi_irq_r) |->
        $past(wr_ctl, 1) || $past(wr_ctl, 2) || $past(wr_ctl, 3))
        else $error("interrupt dropped without a control write");
    ctl_readback_a : assert property (sfr_rd_en && sfr_addr == `SPCS_ADDR_CTRL
        && ctl_age_r != 2'h0 |=> sfr_rdata_r[3:2] == ctl_r[3:2] && sfr_rdata_r[0] == ctl_r[0])
        else $error("control mode or enable read back wrong");
    ss_drive_en_a : assert property (ctl_age_r == 2'h3 |->
        slave_select_pin_oe_r == (ctl_r[0] && ctl_r[3]))
        else $error("select pin drive enable wrong");
    ss_level_a : assert property (slave_select_pin_oe_r && ctl_age_r == 2'h3 |->
        slave_select_pin_out_r == ctl_r[2])
        else $error("driven select level wrong");
    off_quiet_a : assert property (ctl_age_r == 2'h3 && !ctl_r[0] |->
        !sck_oe_r && !mosi_oe_r && !miso_oe_r && !slave_select_pin_oe_r)
        else $error("disabled port drives a pin");
    cfg_readback_a : assert property (sfr_rd_en && sfr_addr == `SPCS_ADDR_CFG
        && cfg_age_r != 2'h0 |=> sfr_rdata_r == {1'b0, cfg_r[6], 6'h00})
        else $error("config read back wrong");
    unmapped_zero_a : assert property (sfr_rd_en && !(sfr_addr inside {`SPCS_ADDR_CTRL,
        `SPCS_ADDR_CFG, `SPCS_ADDR_DATA}) |=> sfr_rdata_r == 8'h00)
        else $error("unmapped read not zero");
    rdata_hold_a : assert property (!sfr_rd_en |=> $stable(sfr_rdata_r))
        else $error("read data changed without a read");
endmodule

bind spcs_top spcs_chk i_spcs_chk (
    .ref_clk(ref_clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
    .sfr_rd_en(sfr_rd_en), .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r),
    .spi_irq_r(spi_irq_r), .sck_oe_r(sck_oe_r), .mosi_oe_r(mosi_oe_r), .miso_oe_r(miso_oe_r),
    .slave_select_pin_in(slave_select_pin_in),
    .slave_select_pin_out_r(slave_select_pin_out_r),
    .slave_select_pin_oe_r(slave_select_pin_oe_r));

// file: tb/spcs_peer.sv
// Far-side peer: frames as link master, answers as a selected slave
`timescale 1ns/100ps
module spcs_peer #(
    parameter logic [7:0] SLV_WORD = 8'h3c
) (
    input  wire logic sck_w,
    input  wire logic mosi_w,
    input  wire logic miso_w,
    input  wire logic ss_w,
    output logic      p_sck,
    output logic      p_mosi,
    output logic      p_miso,
    output logic      p_ss
);
    logic [7:0] s_rx;
    logic [7:0] m_rx;
    logic [2:0] cnt;

    initial begin
        p_sck = 1'b0;
        p_mosi = 1'b0;
        p_miso = 1'b0;
        p_ss = 1'b1;
        cnt = 3'h0;
    end

    // Released data line toggles so a stale level never reads as data
    always #4 if (ss_w) p_miso = ~p_miso;
    always @(negedge ss_w) cnt = 3'h0;
    always @(posedge sck_w) if (!ss_w) p_miso = SLV_WORD[3'h7 - cnt];
    always @(negedge sck_w) begin
        if (!ss_w) begin
            s_rx = {s_rx[6:0], mosi_w};
            cnt = cnt + 3'h1;
        end
    end

    // Clock stands low between frames
    task automatic frame(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            p_mosi = d[i];
            #2;
            p_sck = 1'b1;
            #24;
            m_rx = {m_rx[6:0], miso_w};
            p_sck = 1'b0;
            #22;
        end
        p_mosi = ~p_mosi;
        #40;
    endtask
endmodule

// file: tb/tb.sv
// Self-checking bench for the SPI control block
`include "spcs_defs.svh"
`timescale 1ns/100ps
module tb;
    logic       ref_clk;
    logic       reset;
    logic [7:0] sfr_addr;
    logic       sfr_wr_en;
    logic       sfr_rd_en;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata_r;
    logic       spi_irq_r;
    logic       sck_out_r, sck_oe_r, mosi_out_r, mosi_oe_r, miso_out_r, miso_oe_r;
    logic       ss_out_r, ss_oe_r, sck_w, mosi_w, miso_w, ss_w;
    logic       p_sck, p_mosi, p_miso, p_ss;
    int         fails;
    int         checks_done;
    int         cycles;

    assign sck_w = sck_oe_r ? sck_out_r : p_sck;
    assign mosi_w = mosi_oe_r ? mosi_out_r : p_mosi;
    assign miso_w = miso_oe_r ? miso_out_r : p_miso;
    assign ss_w = ss_oe_r ? ss_out_r : p_ss;

    always #2 ref_clk = ~ref_clk;

    spcs_top #(.SCK_HALF(4), .RX_DEPTH(4)) i_spcs_top (
        .ref_clk(ref_clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
        .sfr_rd_en(sfr_rd_en), .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r),
        .spi_irq_r(spi_irq_r), .sck_in(sck_w), .sck_out_r(sck_out_r), .sck_oe_r(sck_oe_r),
        .mosi_in(mosi_w), .mosi_out_r(mosi_out_r), .mosi_oe_r(mosi_oe_r), .miso_in(miso_w),
        .miso_out_r(miso_out_r), .miso_oe_r(miso_oe_r), .slave_select_pin_in(ss_w),
        .slave_select_pin_out_r(ss_out_r), .slave_select_pin_oe_r(ss_oe_r));

    spcs_peer i_spcs_peer (.sck_w(sck_w), .mosi_w(mosi_w), .miso_w(miso_w), .ss_w(ss_w),
        .p_sck(p_sck), .p_mosi(p_mosi), .p_miso(p_miso), .p_ss(p_ss));

    task automatic conclude();
        if (fails == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            conclude();
        end
    end

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr_en = 1'b1;
        wt(1);
        sfr_wr_en = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        #1;
        sfr_addr = a;
        sfr_rd_en = 1'b1;
        wt(1);
        sfr_rd_en = 1'b0;
        wt(1);
        cmp(sfr_rdata_r, e);
    endtask

    task automatic t_reset();
        rd(`SPCS_ADDR_CTRL, 8'h02);
        rd(`SPCS_ADDR_CFG, 8'h00);
        rd(8'h10, 8'h00);
    endtask

    task automatic t_write_collision_flag();
        wr(`SPCS_ADDR_DATA, 8'h5a);
        wr(`SPCS_ADDR_DATA, 8'hc3);
        rd(`SPCS_ADDR_CTRL, 8'h40);
        wr(`SPCS_ADDR_CTRL, 8'h00);
        rd(`SPCS_ADDR_CTRL, 8'h00);
    endtask

    task automatic t_master();
        wr(`SPCS_ADDR_CFG, 8'h40);
        wr(`SPCS_ADDR_CTRL, 8'h09);
        wt(3);
        cmp({7'h00, ss_oe_r}, 8'h01);
        cmp({7'h00, ss_out_r}, 8'h00);
        wt(80);
        rd(`SPCS_ADDR_CTRL, 8'h0b);
        rd(`SPCS_ADDR_DATA, 8'h3c);
        cmp(i_spcs_peer.s_rx, 8'h5a);
        wr(`SPCS_ADDR_CTRL, 8'h00);
    endtask

    task automatic t_overrun();
        wr(`SPCS_ADDR_CFG, 8'h00);
        wr(`SPCS_ADDR_CTRL, 8'h01);
        // Let the slave side leave its cleared state before the first sck edge
        wt(2);
        for (int i = 0; i < 5; i++) begin
            i_spcs_peer.frame(8'h81 + 8'(i));
            if (i == 0) cmp(i_spcs_peer.m_rx, 8'hff);
        end
        wt(10);
        rd(`SPCS_ADDR_CTRL, 8'h13);
        cmp({7'h00, spi_irq_r}, 8'h01);
        wt(20);
        cmp({7'h00, spi_irq_r}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            rd(`SPCS_ADDR_DATA, 8'h81 + 8'(i));
        end
        wr(`SPCS_ADDR_CTRL, 8'h01);
        wt(3);
        cmp({7'h00, spi_irq_r}, 8'h00);
        rd(`SPCS_ADDR_CTRL, 8'h03);
    endtask

    task automatic t_mode_fault_flag();
        wr(`SPCS_ADDR_CFG, 8'h40);
        wr(`SPCS_ADDR_CTRL, 8'h05);
        i_spcs_peer.p_ss = 1'b0;
        wt(8);
        rd(`SPCS_ADDR_CTRL, 8'h27);
        cmp({7'h00, spi_irq_r}, 8'h01);
        i_spcs_peer.p_ss = 1'b1;
        wt(4);
        wr(`SPCS_ADDR_CTRL, 8'h05);
        wt(3);
        cmp({7'h00, spi_irq_r}, 8'h00);
        rd(`SPCS_ADDR_CTRL, 8'h07);
    endtask

    initial begin
        ref_clk = 1'b0;
        reset = 1'b1;
        sfr_addr = 8'h00;
        sfr_wr_en = 1'b0;
        sfr_rd_en = 1'b0;
        sfr_wdata = 8'h00;
        fails = 0;
        checks_done = 0;
        cycles = 0;
        wt(4);
        reset = 1'b0;
        t_reset();
        t_write_collision_flag();
        t_master();
        t_overrun();
        t_mode_fault_flag();
        conclude();
    end
endmodule
